//--- tss_pkg.sv
// package: constants, states and carrier types of the sensor bus target
package tss_pkg;

   // ---------------------------------------------------------------
   // clocking and timing
   // ---------------------------------------------------------------
   localparam int unsigned CORE_HZ     = 40_000_000;
   localparam int unsigned TIMEOUT_MS  = 25;
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CORE_HZ / 1000);
   localparam int unsigned CONV_MS     = 250;
   localparam int unsigned CONV_CYC    = CONV_MS * (CORE_HZ / 1000);
   localparam int unsigned STRAP_WAIT  = 3;

   // ---------------------------------------------------------------
   // register map and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_RES_UPPER  = 8'h00;
   localparam logic [7:0] OFS_RES_LOWER  = 8'h02;
   localparam logic [7:0] OFS_TIMEOUT    = 8'h22;
   localparam logic [7:0] PTR_RST        = 8'h00;
   localparam logic [7:0] RES_RST        = 8'h00;
   localparam logic [7:0] TIMEOUT_RST    = 8'h00;
   localparam logic [7:0] UNMAPPED_RD    = 8'h00;
   localparam int         TIMEOUT_EN_BIT = 7;

   // ---------------------------------------------------------------
   // bus addresses and byte framing
   // ---------------------------------------------------------------
   localparam logic [6:0] ARA_ADDR = 7'h0c;
   // index = variant * 4 + strap code
   localparam logic [7:0][6:0] TGT_ADDR = {7'h3b, 7'h3a, 7'h4b, 7'h4a,
                                           7'h39, 7'h38, 7'h49, 7'h48};
   localparam logic [3:0] BIT_ACK  = 4'h8;
   localparam logic [3:0] BIT_ZERO = 4'h0;

   // ---------------------------------------------------------------
   // temperature result format
   // ---------------------------------------------------------------
   localparam int         RAW_W      = 12;
   localparam int         RES_W      = 10;
   localparam int         RES_LO_INT = -256;
   localparam int         RES_HI_INT = 511;
   localparam logic [9:0] RES_MIN    = 10'h300;
   localparam logic [9:0] RES_MAX    = 10'h1ff;

   typedef struct packed {
      logic                    valid;
      logic signed [RAW_W-1:0] code;
   } tss_temp_s;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ADDR = 5'h02,
      ST_CMD  = 5'h04,
      ST_DATA = 5'h08,
      ST_TX   = 5'h10
   } tss_state_e;

endpackage

//--- tss_bus_target.sv
// module: two-wire management bus target of the single-zone temperature sensor

`timescale 1ns/10ps

module tss_bus_target #(
   parameter bit          VARIANT        = 1'b0,
   parameter int unsigned TIMEOUT_CYCLES = tss_pkg::TIMEOUT_CYC,
   parameter int unsigned CONV_CYCLES    = tss_pkg::CONV_CYC
) (
   input  wire logic              CORE_CLK,
   input  wire logic              RST_B,
   input  wire logic              BUS_CLK_PIN,
   input  wire logic              BUS_DATA_IN,
   output      logic              BUS_DATA_OUT,
   output      logic              BUS_DATA_OE,
   input  wire logic [1:0]        ADDR_STRAP_LVL,
   input  wire logic              ALERT_ACTIVE,
   input  wire logic              STANDBY,
   input  wire tss_pkg::tss_temp_s TEMP_IN,
   output      logic              CONV_START,
   output      logic              ALERT_ACK,
   output      logic              TIMEOUT_EN
);
   import tss_pkg::*;

   localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
   localparam int CV_W = $clog2(CONV_CYCLES + 1);

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function automatic logic [RES_W-1:0] saturate(input logic signed [RAW_W-1:0] raw);
      int v;
      v = int'(raw);
      if (v <= RES_LO_INT) begin
         saturate = RES_MIN;
      end else if (v >= RES_HI_INT) begin
         saturate = RES_MAX;
      end else begin
         saturate = raw[RES_W-1:0];
      end
   endfunction

   function automatic logic [7:0] reg_read(input logic [7:0] ofs,
                                           input logic [7:0] up,
                                           input logic [7:0] lo,
                                           input logic [7:0] tmo);
      case (ofs)
         OFS_RES_UPPER: reg_read = up;
         OFS_RES_LOWER: reg_read = lo;
         OFS_TIMEOUT:   reg_read = tmo;
         default:       reg_read = UNMAPPED_RD;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // link clock domain: sample data on each bus clock rise
   // ---------------------------------------------------------------
   logic link_bit;
   logic link_tog;

   always_ff @(posedge BUS_CLK_PIN or negedge RST_B) begin
      if (!RST_B) begin
         link_bit <= 1'b1;
         link_tog <= 1'b0;
      end else begin
         link_bit <= BUS_DATA_IN;
         link_tog <= ~link_tog;
      end
   end

   // ---------------------------------------------------------------
   // crossings into the core domain
   // ---------------------------------------------------------------
   logic       scl_s1, scl_s2, scl_d;
   logic       sda_s1, sda_s2, sda_d;
   logic       tog_s1, tog_s2, tog_d;
   logic [1:0] strap_s1, strap_s2;

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         scl_s1   <= 1'b1;
         scl_s2   <= 1'b1;
         scl_d    <= 1'b1;
         sda_s1   <= 1'b1;
         sda_s2   <= 1'b1;
         sda_d    <= 1'b1;
         tog_s1   <= 1'b0;
         tog_s2   <= 1'b0;
         tog_d    <= 1'b0;
         strap_s1 <= 2'h0;
         strap_s2 <= 2'h0;
      end else begin
         scl_s1   <= BUS_CLK_PIN;
         scl_s2   <= scl_s1;
         scl_d    <= scl_s2;
         sda_s1   <= BUS_DATA_IN;
         sda_s2   <= sda_s1;
         sda_d    <= sda_s2;
         tog_s1   <= link_tog;
         tog_s2   <= tog_s1;
         tog_d    <= tog_s2;
         strap_s1 <= ADDR_STRAP_LVL;
         strap_s2 <= strap_s1;
      end
   end

   // bus clock is only observed; no path ever drives it low
   wire scl_fall  = scl_d & ~scl_s2;
   wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
   wire stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;
   wire bit_ev    = tog_s2 ^ tog_d;
   wire activity  = (scl_s2 ^ scl_d) | (sda_s2 ^ sda_d);

   // ---------------------------------------------------------------
   // address strap, taken once after reset release
   // ---------------------------------------------------------------
   logic [1:0] strap_cnt;
   logic       strap_taken;
   logic [1:0] strap_code;

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         strap_cnt   <= 2'h0;
         strap_taken <= 1'b0;
         strap_code  <= 2'h0;
      end else if (!strap_taken) begin
         strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == 2'(STRAP_WAIT)) begin
            strap_taken <= 1'b1;
            strap_code  <= strap_s2;
         end
      end
   end

   wire [6:0] own_addr = TGT_ADDR[{VARIANT, strap_code}];

   // ---------------------------------------------------------------
   // protocol state
   // ---------------------------------------------------------------
   tss_state_e state;
   logic [3:0] bcnt;
   logic [7:0] shift_in;
   logic [7:0] tx_byte;
   logic [7:0] pointer;
   logic [7:0] res_upper;
   logic [7:0] res_lower;
   logic [7:0] timeout_ctrl;
   logic       lock;
   logic       to_hit;
   logic       ara_sel;

   wire [7:0] next_shift = {shift_in[6:0], link_bit};
   wire       at_ack     = (bcnt == BIT_ACK);
   wire       own_hit    = strap_taken & (shift_in[7:1] == own_addr);
   wire       ara_hit    = strap_taken & (shift_in[7:1] == ARA_ADDR)
                           & shift_in[0] & ALERT_ACTIVE;
   wire       in_addr    = (state == ST_ADDR);
   wire       in_cmd     = (state == ST_CMD);
   wire       in_data    = (state == ST_DATA);
   wire       in_tx      = (state == ST_TX);

   // foreign addresses and surplus bytes get no acknowledge
   wire ack_ok = at_ack & ((in_addr & (own_hit | ara_hit))
                           | in_cmd | in_data);

   wire byte_end  = bit_ev & at_ack;
   wire host_nack = link_bit;
   wire rd_start  = byte_end & in_addr & own_hit & shift_in[0];
   wire rd_again  = byte_end & in_tx & ~host_nack & ~ara_sel;
   wire tx_load   = rd_start | rd_again;
   wire cmd_done  = byte_end & in_cmd;
   wire wr_stb    = byte_end & in_data;

   wire [7:0] rd_value  = reg_read(pointer, res_upper, res_lower, timeout_ctrl);
   wire [7:0] ara_value = {own_addr, 1'b0};

   // ---------------------------------------------------------------
   // transaction sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state    <= ST_IDLE;
         bcnt     <= BIT_ZERO;
         shift_in <= 8'h00;
         tx_byte  <= 8'h00;
         ara_sel  <= 1'b0;
      end else if (to_hit | stop_det) begin
         state <= ST_IDLE;
         bcnt  <= BIT_ZERO;
      end else if (start_det) begin
         state <= ST_ADDR;
         bcnt  <= BIT_ZERO;
      end else if (bit_ev & ~at_ack) begin
         shift_in <= next_shift;
         bcnt     <= bcnt + 4'h1;
      end else if (byte_end) begin
         bcnt <= BIT_ZERO;
         case (state)
            ST_ADDR: begin
               if (own_hit & shift_in[0]) begin
                  state   <= ST_TX;
                  tx_byte <= rd_value;
                  ara_sel <= 1'b0;
               end else if (own_hit) begin
                  state <= ST_CMD;
               end else if (ara_hit) begin
                  state   <= ST_TX;
                  tx_byte <= ara_value;
                  ara_sel <= 1'b1;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_CMD: begin
               state <= ST_DATA;
            end
            ST_DATA: begin
               state <= ST_IDLE;
            end
            ST_TX: begin
               if (host_nack | ara_sel) begin
                  state <= ST_IDLE;
               end else begin
                  tx_byte <= rd_value;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // data line drive, set after a clock fall, released at once on timeout, start or stop
   // ---------------------------------------------------------------
   wire [2:0] tx_idx   = 3'(4'h7 - bcnt);
   wire       drive_tx = in_tx & ~bcnt[3] & ~tx_byte[tx_idx];
   wire       next_oe  = ack_ok | drive_tx;

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         BUS_DATA_OE  <= 1'b0;
         BUS_DATA_OUT <= 1'b0;
      end else if (to_hit | start_det | stop_det) begin
         BUS_DATA_OE <= 1'b0;
      end else if (scl_fall) begin
         BUS_DATA_OE <= next_oe;
      end
   end

   // ---------------------------------------------------------------
   // pointer and software register
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         pointer      <= PTR_RST;
         timeout_ctrl <= TIMEOUT_RST;
      end else begin
         if (cmd_done) begin
            pointer <= shift_in;
         end
         // send byte ends here too, leaving only the pointer changed
         if (wr_stb & (pointer == OFS_TIMEOUT)) begin
            timeout_ctrl <= {shift_in[TIMEOUT_EN_BIT], 7'h00};
         end
      end
   end

   // ---------------------------------------------------------------
   // temperature result and read interlock
   // ---------------------------------------------------------------
   wire [RES_W-1:0] res_next = saturate(TEMP_IN.code);
   wire lock_set = tx_load & (pointer == OFS_RES_UPPER);
   wire lock_clr = tx_load & (pointer == OFS_RES_LOWER);

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         res_upper <= RES_RST;
         res_lower <= RES_RST;
         lock      <= 1'b0;
      end else begin
         if (TEMP_IN.valid) begin
            res_upper <= res_next[9:2];
         end
         if (TEMP_IN.valid & ~lock) begin
            res_lower <= {res_next[1:0], 6'h00};
         end
         if (lock_set) begin
            lock <= 1'b1;
         end else if (lock_clr) begin
            lock <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // inactivity timeout
   // ---------------------------------------------------------------
   logic [TO_W-1:0] to_cnt;
   wire to_run = timeout_ctrl[TIMEOUT_EN_BIT] & (state != ST_IDLE);

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         to_cnt <= '0;
         to_hit <= 1'b0;
      end else if (!to_run | activity | to_hit) begin
         to_cnt <= '0;
         to_hit <= 1'b0;
      end else begin
         to_cnt <= to_cnt + TO_W'(1);
         to_hit <= (to_cnt == TO_W'(TIMEOUT_CYCLES - 2));
      end
   end

   // ---------------------------------------------------------------
   // conversion scheduler
   // ---------------------------------------------------------------
   logic [CV_W-1:0] cv_cnt;
   wire cv_wrap = (cv_cnt == CV_W'(CONV_CYCLES - 1));

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         cv_cnt     <= '0;
         CONV_START <= 1'b0;
      end else if (STANDBY) begin
         cv_cnt     <= '0;
         CONV_START <= 1'b0;
      end else begin
         cv_cnt     <= cv_wrap ? '0 : cv_cnt + CV_W'(1);
         CONV_START <= cv_wrap;
      end
   end

   // ---------------------------------------------------------------
   // status outputs
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ALERT_ACK  <= 1'b0;
         TIMEOUT_EN <= 1'b0;
      end else begin
         ALERT_ACK  <= byte_end & in_addr & ~own_hit & ara_hit;
         TIMEOUT_EN <= timeout_ctrl[TIMEOUT_EN_BIT];
      end
   end

endmodule // tss_bus_target

//--- tss_bus_target_sva.sv
// checker: port assertions of the sensor bus target
`timescale 1ns/10ps
module tss_bus_target_chk #(
   parameter int unsigned TIMEOUT_CYCLES = 2000,
   parameter int unsigned CONV_CYCLES    = 500
) (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic BUS_CLK_PIN,
   input wire logic BUS_DATA_IN,
   input wire logic BUS_DATA_OUT,
   input wire logic BUS_DATA_OE,
   input wire logic ALERT_ACTIVE,
   input wire logic STANDBY,
   input wire logic CONV_START,
   input wire logic ALERT_ACK,
   input wire logic TIMEOUT_EN
);
   logic [31:0] gap;
   logic        seen;
   logic [31:0] quiet;
   logic [1:0]  last;
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_B);
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         gap   <= '0;
         seen  <= 1'b0;
         quiet <= '0;
         last  <= 2'b11;
      end else begin
         last  <= {BUS_CLK_PIN, BUS_DATA_IN};
         quiet <= (last != {BUS_CLK_PIN, BUS_DATA_IN}) ? '0 : quiet + 1;
         gap   <= (STANDBY || CONV_START) ? '0 : gap + 1;
         seen  <= !STANDBY && (seen || CONV_START);
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_oe_clk_low;
      $changed(BUS_DATA_OE) |-> !BUS_CLK_PIN;
   endproperty
   a_oe_clk_low: assert property (p_oe_clk_low)
      else $error("data drive changed while bus clock high");
   property p_out_low;
      BUS_DATA_OUT == 1'b0;
   endproperty
   a_out_low: assert property (p_out_low)
      else $error("data output not low");
   property p_tmo_rst;
      $rose(RST_B) |-> !TIMEOUT_EN;
   endproperty
   a_tmo_rst: assert property (p_tmo_rst)
      else $error("timeout enable set after reset");
   property p_tmo_drop;
      TIMEOUT_EN && quiet > TIMEOUT_CYCLES + 8 |-> !BUS_DATA_OE;
   endproperty
   a_tmo_drop: assert property (p_tmo_drop)
      else $error("data drive held past timeout");
   property p_conv_gap;
      CONV_START && seen |-> gap == CONV_CYCLES - 1;
   endproperty
   a_conv_gap: assert property (p_conv_gap)
      else $error("conversion spacing wrong");
   property p_conv_due;
      !STANDBY && seen |-> gap < CONV_CYCLES;
   endproperty
   a_conv_due: assert property (p_conv_due)
      else $error("conversion start missing");
   property p_conv_once;
      CONV_START |=> !CONV_START;
   endproperty
   a_conv_once: assert property (p_conv_once)
      else $error("conversion start longer than one cycle");
   property p_standby;
      STANDBY && $past(STANDBY) |-> !CONV_START;
   endproperty
   a_standby: assert property (p_standby)
      else $error("conversion started in standby");
   property p_ara_ack;
      ALERT_ACK |-> ALERT_ACTIVE ##1 !ALERT_ACK;
   endproperty
   a_ara_ack: assert property (p_ara_ack)
      else $error("alert acknowledge without alert or too long");
endmodule // tss_bus_target_chk

bind tss_bus_target tss_bus_target_chk #(
   .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
   .CONV_CYCLES(CONV_CYCLES)
) u_chk (
   .CORE_CLK(CORE_CLK),
   .RST_B(RST_B),
   .BUS_CLK_PIN(BUS_CLK_PIN),
   .BUS_DATA_IN(BUS_DATA_IN),
   .BUS_DATA_OUT(BUS_DATA_OUT),
   .BUS_DATA_OE(BUS_DATA_OE),
   .ALERT_ACTIVE(ALERT_ACTIVE),
   .STANDBY(STANDBY),
   .CONV_START(CONV_START),
   .ALERT_ACK(ALERT_ACK),
   .TIMEOUT_EN(TIMEOUT_EN)
);

//--- tss_host_model.sv
// host model: bus clock and open-drain data of the management bus host
`timescale 1ns/10ps
module tss_host_model (
   input  wire logic clk,
   input  wire logic sda_in,
   output      logic scl,
   output      logic sda_low
);
   // phase length in link clock ticks, keeps the bus at or under 400 kHz
   localparam int Q = 105;
   // ----------------------------------------
   // bus phases, clock stands high between frames
   // ----------------------------------------
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wt();
      repeat (Q) @(negedge clk);
   endtask
   task automatic start();
      sda_low = 1'b0;
      wt();
      scl = 1'b1;
      wt();
      sda_low = 1'b1;
      wt();
      scl = 1'b0;
      wt();
   endtask
   task automatic bitio(input logic b, output logic r);
      sda_low = !b;
      wt();
      scl = 1'b1;
      wt();
      r = sda_in;
      wt();
      scl = 1'b0;
      wt();
   endtask
   task automatic io(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bitio(d[i], b);
         r[i] = b;
      end
      bitio(m, b);
      a = !b;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      wt();
      scl = 1'b1;
      wt();
      sda_low = 1'b0;
      wt();
   endtask
endmodule // tss_host_model

//--- tb_top.sv
// testbench: sensor bus target driven through the host model
`timescale 1ns/10ps
module tb_top;
   import tss_pkg::*;
   localparam int unsigned TMO  = 1000;
   localparam int unsigned CONV = 300;
   localparam logic [6:0] TBL [4] = '{7'h48, 7'h49, 7'h38, 7'h39};
   logic       CORE_CLK, RST_B, ALERT_ACTIVE, STANDBY, scl, host_low, sda, a, link_clk;
   logic       BUS_DATA_OUT, BUS_DATA_OE, CONV_START, ALERT_ACK, TIMEOUT_EN;
   logic [1:0] ADDR_STRAP_LVL;
   tss_temp_s  TEMP_IN;
   logic [6:0] own;
   logic [7:0] r, v;
   int         errors = 0, checks = 0, n_ack = 0, n_conv = 0;
   assign sda = !(host_low || BUS_DATA_OE);
   tss_bus_target #(.VARIANT(1'b0), .TIMEOUT_CYCLES(TMO), .CONV_CYCLES(CONV)) u_dut (
      .CORE_CLK(CORE_CLK), .RST_B(RST_B), .BUS_CLK_PIN(scl), .BUS_DATA_IN(sda),
      .BUS_DATA_OUT(BUS_DATA_OUT), .BUS_DATA_OE(BUS_DATA_OE),
      .ADDR_STRAP_LVL(ADDR_STRAP_LVL), .ALERT_ACTIVE(ALERT_ACTIVE), .STANDBY(STANDBY),
      .TEMP_IN(TEMP_IN), .CONV_START(CONV_START), .ALERT_ACK(ALERT_ACK),
      .TIMEOUT_EN(TIMEOUT_EN));
   tss_host_model u_h (.clk(link_clk), .sda_in(sda), .scl(scl), .sda_low(host_low));
   // ----------------------------------------
   // clock, monitors and helpers
   // ----------------------------------------
   initial begin
      CORE_CLK = 1'b0;
      forever #12.5 CORE_CLK = ~CORE_CLK;
   end
   // host timing clock, unrelated in phase to the core clock
   initial begin
      link_clk = 1'b0;
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   always @(posedge CORE_CLK) begin
      n_ack  <= n_ack + int'(ALERT_ACK);
      n_conv <= n_conv + int'(CONV_START);
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   function automatic logic [9:0] res(input int c);
      if (c <= -256) return 10'h300;
      if (c >= 511) return 10'h1ff;
      return 10'(c);
   endfunction
   task automatic do_reset(input logic [1:0] s);
      @(negedge CORE_CLK);
      RST_B = 1'b0;
      ADDR_STRAP_LVL = s;
      own = TBL[s];
      repeat (7) @(negedge CORE_CLK);
      RST_B = 1'b1;
      repeat (12) @(negedge CORE_CLK);
   endtask
   task automatic push(input int c);
      @(negedge CORE_CLK);
      TEMP_IN.code = 12'(c);
      TEMP_IN.valid = 1'b1;
      @(negedge CORE_CLK);
      TEMP_IN.valid = 1'b0;
      @(negedge CORE_CLK);
   endtask
   task automatic hdr(input logic [7:0] c);
      u_h.start();
      u_h.io({own, 1'b0}, 1'b1, v, a);
      chk(8'(a), 8'h01);
      u_h.io(c, 1'b1, v, a);
      chk(8'(a), 8'h01);
   endtask
   task automatic rx(output logic [7:0] d);
      u_h.start();
      u_h.io({own, 1'b1}, 1'b1, v, a);
      chk(8'(a), 8'h01);
      u_h.io(8'hff, 1'b1, d, a);
      u_h.stop();
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      hdr(c);
      u_h.io(d, 1'b1, v, a);
      u_h.stop();
   endtask
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      hdr(c);
      rx(d);
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      int         k;
      int         cs [4];
      logic [9:0] e;
      logic [7:0] w;
      RST_B = 1'b0;
      STANDBY = 1'b0;
      ALERT_ACTIVE = 1'b0;
      TEMP_IN = '0;
      ADDR_STRAP_LVL = 2'h0;
      void'($urandom(50));
      for (int s = 3; s >= 0; s--) begin
         do_reset(2'(s));
         rx(r);
         chk(r, 8'h00);
      end
      @(negedge CORE_CLK);
      ADDR_STRAP_LVL = 2'h1;
      for (int i = 0; i < 2; i++) begin
         w = i ? {7'h50 + 7'($urandom % 48), 1'b0} : {7'h49, 1'b0};
         u_h.start();
         u_h.io(w, 1'b1, v, a);
         u_h.stop();
         chk(8'(a), 8'h00);
      end
      rd(8'h22, r);
      chk(r, 8'h00);
      chk(8'(TIMEOUT_EN), 8'h00);
      wr(8'h22, 8'($urandom) | 8'h80);
      chk(8'(TIMEOUT_EN), 8'h01);
      rd(8'h22, r);
      chk(r, 8'h80);
      rx(r);
      chk(r, 8'h80);
      u_h.start();
      w = {own, 1'b0};
      for (int i = 7; i >= 0; i--) u_h.bitio(w[i], a);
      chk(8'(BUS_DATA_OE), 8'h01);
      repeat (TMO + 20) @(negedge CORE_CLK);
      chk(8'(BUS_DATA_OE), 8'h00);
      u_h.stop();
      wr(8'h22, 8'h7f);
      chk(8'(TIMEOUT_EN), 8'h00);
      cs = '{-300, -256, 511, 0};
      cs[3] = int'($urandom % 768) - 256;
      foreach (cs[i]) begin
         push(cs[i]);
         e = res(cs[i]);
         rd(8'h00, r);
         chk(r, e[9:2]);
         rd(8'h02, r);
         chk(r, {e[1:0], 6'h00});
      end
      push(-3);
      rd(8'h00, r);
      chk(r, 8'hff);
      push(6);
      rd(8'h02, r);
      chk(r, 8'h40);
      rx(r);
      chk(r, 8'h40);
      push(6);
      hdr(8'h02);
      u_h.stop();
      rx(r);
      chk(r, 8'h80);
      rx(r);
      chk(r, 8'h80);
      wr(8'h05, 8'h5a);
      rd(8'h05, r);
      chk(r, 8'h00);
      wr(8'h00, 8'h5a);
      rd(8'h00, r);
      chk(r, 8'h01);
      for (int i = 1; i >= 0; i--) begin
         @(negedge CORE_CLK);
         ALERT_ACTIVE = 1'(i);
         k = n_ack;
         u_h.start();
         u_h.io({7'h0c, 1'b1}, 1'b1, v, a);
         chk(8'(a), 8'(i));
         if (a) u_h.io(8'hff, 1'b1, r, a);
         u_h.stop();
         chk(8'(n_ack - k), 8'(i));
      end
      chk(r, {own, 1'b0});
      k = n_conv;
      repeat (3 * CONV) @(negedge CORE_CLK);
      chk(8'(n_conv - k), 8'h03);
      STANDBY = 1'b1;
      @(negedge CORE_CLK);
      k = n_conv;
      repeat (3 * CONV) @(negedge CORE_CLK);
      chk(8'(n_conv - k), 8'h00);
      rd(8'h00, r);
      chk(r, 8'h01);
      @(negedge CORE_CLK);
      STANDBY = 1'b0;
      final_report();
   end
   initial begin
      repeat (110000) @(negedge CORE_CLK);
      errors++;
      final_report();
   end
endmodule // tb_top
